//--- iox_expander.sv
// I2C 16-bit port expander slave: reset, port drivers, change alert and bus framing.
`timescale 1ns/1ps
`include "iox_consts.svh"

module iox_expander #(
    parameter int unsigned FILT_LEN  = `IOX_FILT_LEN,
    parameter int unsigned ALERT_CYC = `IOX_ALERT_VALID_NS / `IOX_CLK_PERIOD_NS
) (
    input  wire logic                ref_clk,
    input  wire logic                arst_n,
    input  wire logic                portSupplyOk,
    input  wire logic                addrSel,
    input  wire iox_pkg::iox_bus_type busIn,
    output logic                     sdaOut,
    output logic                     sdaOe_n,
    input  wire logic [15:0]         portIn,
    output logic      [15:0]         portOut,
    output logic      [15:0]         portOe_n,
    output logic                     alertOut,
    output logic                     alertOe_n
);

    localparam int ALERT_CYC_I = ALERT_CYC;

    // Local aliases of the bus states, so the state machine reads without scoping.
    localparam iox_pkg::iox_state_type IDLE     = iox_pkg::IDLE;
    localparam iox_pkg::iox_state_type ADDR     = iox_pkg::ADDR;
    localparam iox_pkg::iox_state_type ADDR_ACK = iox_pkg::ADDR_ACK;
    localparam iox_pkg::iox_state_type WR       = iox_pkg::WR;
    localparam iox_pkg::iox_state_type WR_ACK   = iox_pkg::WR_ACK;
    localparam iox_pkg::iox_state_type RD       = iox_pkg::RD;
    localparam iox_pkg::iox_state_type RD_ACK   = iox_pkg::RD_ACK;

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers and glitch filter.

    logic [1:0]          lnSync1;
    logic [1:0]          lnSync2;
    logic                lnFilt [2];
    logic [FILT_LEN-1:0] lnHist [2];
    logic [15:0]         portSync1;
    logic [15:0]         portSync2;
    logic                supSync1;
    logic                supSync2;
    logic                addrSync1;
    logic                addrSync2;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lnSync1   <= 2'h3;
            lnSync2   <= 2'h3;
            portSync1 <= 16'h0000;
            portSync2 <= 16'h0000;
            supSync1  <= 1'b0;
            supSync2  <= 1'b0;
            addrSync1 <= 1'b0;
            addrSync2 <= 1'b0;
        end else begin
            lnSync1   <= {busIn.scl, busIn.sda};
            lnSync2   <= lnSync1;
            portSync1 <= portIn;
            portSync2 <= portSync1;
            supSync1  <= portSupplyOk;
            supSync2  <= supSync1;
            addrSync1 <= addrSel;
            addrSync2 <= addrSync1;
        end
    end

    // A level is accepted only after it has held for the whole history window.
    for (genvar i = 0; i < 2; i++) begin : gFilt
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                lnHist[i] <= '1;
                lnFilt[i] <= 1'b1;
            end else begin
                lnHist[i] <= {lnHist[i][FILT_LEN-2:0], lnSync2[i]};
                if (&lnHist[i]) begin
                    lnFilt[i] <= 1'b1;
                end else if (~|lnHist[i]) begin
                    lnFilt[i] <= 1'b0;
                end
            end
        end
    end

    logic scl;
    logic sda;
    logic sclPrev;
    logic sdaPrev;
    logic sclRise;
    logic sclFall;
    logic startEvt;
    logic stopEvt;
    logic softRst;

    assign scl      = lnFilt[1];
    assign sda      = lnFilt[0];
    assign sclRise  = scl && !sclPrev;
    assign sclFall  = !scl && sclPrev;
    assign startEvt = scl && sclPrev && sdaPrev && !sda;
    assign stopEvt  = scl && sclPrev && !sdaPrev && sda;
    assign softRst  = !supSync2;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= scl;
            sdaPrev <= sda;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus state machine and registers.

    iox_pkg::iox_state_type state;
    iox_pkg::iox_regs_type  regs;
    logic [7:0]  cmd;
    logic [7:0]  shiftReg;
    logic [7:0]  txShift;
    logic [3:0]  bitCnt;
    logic        own;
    logic        rdDir;
    logic        firstByte;
    logic        nacked;
    logic        sdaLow;
    logic        ownStop;
    logic        readClr;
    logic        errClr;
    logic [15:0] inputVal;
    logic [7:0]  rdByte;
    logic [15:0] grpVal;
    logic        addrMatch;

    assign inputVal  = portSync2 ^ regs.polarity;
    assign addrMatch = shiftReg[7:1] == {`IOX_ADDR_BASE, addrSync2};

    always_comb begin
        unique case (cmd[2:1])
            `IOX_GRP_INPUT:  grpVal = inputVal;
            `IOX_GRP_OUTPUT: grpVal = regs.outLatch;
            `IOX_GRP_POLARITY: grpVal = regs.polarity;
            `IOX_GRP_CONFIG: grpVal = regs.direction;
        endcase
        rdByte = cmd[0] ? grpVal[15:8] : grpVal[7:0];
    end

    // Foreign read acknowledged while the pointer is 00h falsely clears the alert.
    assign errClr  = (state == ADDR_ACK) && sclRise && !own && shiftReg[`IOX_RW_BIT] && !sda
                     && (cmd == `IOX_CMD_INPUT0);
    assign readClr = (state == RD_ACK) && sclRise && (cmd[2:1] == `IOX_GRP_INPUT);
    // A nacked read is already idle when its stop arrives, so ownership decides alone.
    assign ownStop = stopEvt && own;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state     <= IDLE;
            bitCnt    <= 4'h0;
            shiftReg  <= 8'h00;
            txShift   <= 8'h00;
            own       <= 1'b0;
            rdDir     <= 1'b0;
            firstByte <= 1'b0;
            nacked    <= 1'b0;
            sdaLow    <= 1'b0;
        end else if (softRst) begin
            state     <= IDLE;
            bitCnt    <= 4'h0;
            own       <= 1'b0;
            nacked    <= 1'b0;
            sdaLow    <= 1'b0;
        end else if (startEvt) begin
            state  <= ADDR;
            bitCnt <= 4'h0;
            own    <= 1'b0;
            sdaLow <= 1'b0;
        end else if (stopEvt) begin
            state  <= IDLE;
            own    <= 1'b0;
            sdaLow <= 1'b0;
        end else if (sclRise) begin
            unique case (state)
                ADDR, WR: begin
                    shiftReg <= {shiftReg[6:0], sda};
                    bitCnt   <= bitCnt + 4'h1;
                end
                RD_ACK: nacked <= sda;
                default: ;
            endcase
        end else if (sclFall) begin
            unique case (state)
                ADDR: begin
                    if (bitCnt == 4'h8) begin
                        state  <= ADDR_ACK;
                        own    <= addrMatch;
                        rdDir  <= shiftReg[`IOX_RW_BIT];
                        sdaLow <= addrMatch;
                    end
                end
                ADDR_ACK: begin
                    if (!own) begin
                        state <= IDLE;
                        sdaLow <= 1'b0;
                    end else if (rdDir) begin
                        state   <= RD;
                        sdaLow  <= !rdByte[7];
                        txShift <= {rdByte[6:0], 1'b0};
                        bitCnt  <= 4'h1;
                    end else begin
                        state     <= WR;
                        sdaLow    <= 1'b0;
                        bitCnt    <= 4'h0;
                        firstByte <= 1'b1;
                    end
                end
                WR: begin
                    if (bitCnt == 4'h8) begin
                        state     <= WR_ACK;
                        sdaLow    <= 1'b1;
                        firstByte <= 1'b0;
                    end
                end
                WR_ACK: begin
                    state  <= WR;
                    sdaLow <= 1'b0;
                    bitCnt <= 4'h0;
                end
                RD: begin
                    if (bitCnt == 4'h8) begin
                        state  <= RD_ACK;
                        sdaLow <= 1'b0;
                    end else begin
                        sdaLow  <= !txShift[7];
                        txShift <= {txShift[6:0], 1'b0};
                        bitCnt  <= bitCnt + 4'h1;
                    end
                end
                RD_ACK: begin
                    if (nacked) begin
                        state  <= IDLE;
                        sdaLow <= 1'b0;
                    end else begin
                        state   <= RD;
                        sdaLow  <= !rdByte[7];
                        txShift <= {rdByte[6:0], 1'b0};
                        bitCnt  <= 4'h1;
                    end
                end
                default: ;
            endcase
        end
    end

    // The pointer toggles within its register pair after each data byte.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd            <= `IOX_RST_CMD;
            regs.outLatch  <= `IOX_RST_OUTPUT;
            regs.polarity  <= `IOX_RST_POLARITY;
            regs.direction <= `IOX_RST_CONFIG;
        end else if (softRst) begin
            cmd            <= `IOX_RST_CMD;
            regs.outLatch  <= `IOX_RST_OUTPUT;
            regs.polarity  <= `IOX_RST_POLARITY;
            regs.direction <= `IOX_RST_CONFIG;
        end else if (sclFall && !startEvt && !stopEvt) begin
            if (state == WR && bitCnt == 4'h8) begin
                if (firstByte) begin
                    cmd <= shiftReg;
                end else begin
                    unique case (cmd[2:1])
                        `IOX_GRP_OUTPUT: begin
                            if (cmd[0]) regs.outLatch[15:8] <= shiftReg;
                            else regs.outLatch[7:0] <= shiftReg;
                        end
                        `IOX_GRP_POLARITY: begin
                            if (cmd[0]) regs.polarity[15:8] <= shiftReg;
                            else regs.polarity[7:0] <= shiftReg;
                        end
                        `IOX_GRP_CONFIG: begin
                            if (cmd[0]) regs.direction[15:8] <= shiftReg;
                            else regs.direction[7:0] <= shiftReg;
                        end
                        default: ;
                    endcase
                    cmd <= {cmd[7:1], ~cmd[0]};
                end
            end else if ((state == RD_ACK && !nacked) || (state == ADDR_ACK && own && rdDir)) begin
                cmd <= {cmd[7:1], ~cmd[0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Change alert.

    logic [15:0] snap;
    logic [15:0] mismatch;
    logic        mismatchAny;
    logic        holdOff;
    logic        alert;
    logic [$clog2(ALERT_CYC+1)-1:0] alertCnt;

    // Only input-mode pins compare; switching a pin to input exposes any stale snapshot.
    assign mismatch    = (portSync2 ^ snap) & regs.direction;
    assign mismatchAny = |mismatch;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            snap <= 16'h0000;
        end else if (softRst || readClr || ownStop || errClr) begin
            snap <= portSync2;
        end
    end

    // After our own transfer the alert stays quiet until one more SCL rise on an idle bus.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            holdOff <= 1'b0;
        end else if (softRst) begin
            holdOff <= 1'b0;
        end else if (ownStop) begin
            holdOff <= 1'b1;
        end else if (sclRise && state == IDLE) begin
            holdOff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            alertCnt <= '0;
            alert    <= 1'b0;
        end else if (softRst || !mismatchAny) begin
            alertCnt <= '0;
            alert    <= 1'b0;
        end else if (!holdOff && !alert) begin
            if (alertCnt == ($clog2(ALERT_CYC+1))'(ALERT_CYC - 1)) begin
                alert <= 1'b1;
            end else begin
                alertCnt <= alertCnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    assign sdaOut    = 1'b0;
    assign sdaOe_n   = !sdaLow;
    assign portOut   = regs.outLatch;
    assign portOe_n  = regs.direction;
    assign alertOut  = 1'b0;
    assign alertOe_n = !alert;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence ownAddrAck;
        state == ADDR_ACK && own && sclRise;
    endsequence

    sequence stopOfOwn;
        ownStop;
    endsequence

    AST_POR_DEFAULTS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        softRst |=> (portOe_n == `IOX_RST_CONFIG) && (state == IDLE) && sdaOe_n)
        else $error("power-on reset did not restore defaults");
    AST_DIR_DRIVE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $fell(regs.direction[0]) |-> !portOe_n[0] && portOut[0] == regs.outLatch[0])
        else $error("output pin not driven from latch");
    AST_ALERT_DELAY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(alert) |-> $past(alertCnt) == ALERT_CYC_I - 1 && $past(mismatchAny))
        else $error("alert asserted without full valid delay");
    AST_ALERT_CAUSE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !alertOe_n |-> mismatchAny || $past(mismatchAny))
        else $error("alert without input-mode mismatch");
    AST_RETURN_CLEAR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !mismatchAny |=> alertOe_n)
        else $error("alert not released after pins returned");
    AST_READ_CLEAR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        readClr && !softRst |=> snap == $past(portSync2))
        else $error("input read did not rebase snapshot");
    AST_STOP_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        stopOfOwn and !softRst |=> holdOff ##1 (!$rose(alert) throughout holdOff[*1]))
        else $error("alert not held off after stop");
    AST_ADDR_ACK: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ownAddrAck |-> !sdaOe_n ##1 (!sdaOe_n || state != ADDR_ACK))
        else $error("own address not acknowledged");
    AST_RESTART_DELAY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        alert ##1 !mismatchAny ##1 mismatchAny && !holdOff |-> !alert [*2])
        else $error("re-detected alert skipped valid delay");

endmodule // iox_expander

//--- iox_consts.svh
// Constants for the I2C port expander: address, command codes, reset values and timing.
`ifndef IOX_CONSTS_SVH
`define IOX_CONSTS_SVH

`define IOX_ADDR_BASE      6'h10
`define IOX_RW_BIT         0
`define IOX_CMD_INPUT0     8'h00
`define IOX_GRP_INPUT      2'h0
`define IOX_GRP_OUTPUT     2'h1
`define IOX_GRP_POLARITY   2'h2
`define IOX_GRP_CONFIG     2'h3
`define IOX_RST_OUTPUT     16'hFFFF
`define IOX_RST_POLARITY   16'h0000
`define IOX_RST_CONFIG     16'hFFFF
`define IOX_RST_CMD        8'h00
`define IOX_CLK_PERIOD_NS  4
`define IOX_ALERT_VALID_NS 4000
`define IOX_FILT_LEN       3

`endif

//--- iox_pkg.sv
// Types shared by the I2C port expander.
package iox_pkg;

    typedef enum logic [2:0] {
        IDLE,
        ADDR,
        ADDR_ACK,
        WR,
        WR_ACK,
        RD,
        RD_ACK
    } iox_state_type;

    typedef struct packed {
        logic scl;
        logic sda;
    } iox_bus_type;

    typedef struct packed {
        logic [15:0] outLatch;
        logic [15:0] polarity;
        logic [15:0] direction;
    } iox_regs_type;

endpackage

//--- iox_master.sv
// Behavioural bus master model that drives the expander's serial pins.
`timescale 1ns/1ps
module iox_master (
    input  wire logic            sdaOut,
    input  wire logic            sdaOe_n,
    output iox_pkg::iox_bus_type busIn
);
    logic       scl;
    logic       sdaDrv;
    logic       otherAck;
    logic [7:0] rdByte;
    event       rdDone;

    // Wired-AND with pull-up: a released line reads high, never the last value.
    assign busIn = {scl, sdaDrv & (sdaOe_n | sdaOut) & ~otherAck};

    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
        otherAck = 1'b0;
        rdByte = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data moves only while SCL is low; it is sampled in the high phase.
    task automatic bitx(input logic b, output logic s);
        scl = 1'b0;
        #16 sdaDrv = b;
        #16 scl = 1'b1;
        #16 s = busIn.sda;
        #16;
    endtask

    // Entered only from an idle bus with both lines high.
    task automatic start();
        #16 sdaDrv = 1'b0;
        #16;
    endtask

    // The trailing pulse on an idle bus lets the alert logic resume.
    task automatic stop();
        scl = 1'b0;
        #16 sdaDrv = 1'b0;
        #16 scl = 1'b1;
        #16 sdaDrv = 1'b1;
        #48 scl = 1'b0;
        #32 scl = 1'b1;
        #32;
    endtask

    // The oth flag lets a second slave on the bus acknowledge the byte.
    task automatic wbyte(input logic [7:0] d, input logic oth, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], s);
        scl = 1'b0;
        #16 sdaDrv = 1'b1;
        otherAck = oth;
        #16 scl = 1'b1;
        #16 ack = busIn.sda;
        #16 scl = 1'b0;
        #8 otherAck = 1'b0;
    endtask

    task automatic rbyte(input logic last);
        logic s;
        for (int i = 0; i < 8; i++) begin
            bitx(1'b1, s);
            rdByte = {rdByte[6:0], s};
        end
        bitx(last, s);
        ->rdDone;
    endtask
endmodule // iox_master

//--- tb.sv
// Self-checking testbench of the port expander against a bus master model.
`timescale 1ns/1ps
module tb;
    localparam int ACYC = 20;
    logic                 ref_clk;
    logic                 arst_n;
    logic                 portSupplyOk;
    logic                 addrSel;
    logic [15:0]          ext;
    iox_pkg::iox_bus_type busIn;
    logic                 sdaOut;
    logic                 sdaOe_n;
    logic [15:0]          portIn;
    logic [15:0]          portOut;
    logic [15:0]          portOe_n;
    logic                 alertOut;
    logic                 alertOe_n;
    logic                 ack;
    logic [31:0]          rnd;
    logic [15:0]          pins;
    logic [15:0]          expQ[$];
    int                   mismatches;
    int                   checked;
    int                   seed = 48;

    iox_expander #(.FILT_LEN(3), .ALERT_CYC(ACYC)) dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .portSupplyOk(portSupplyOk),
        .addrSel(addrSel), .busIn(busIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
        .portIn(portIn), .portOut(portOut), .portOe_n(portOe_n),
        .alertOut(alertOut), .alertOe_n(alertOe_n));
    iox_master m (.sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .busIn(busIn));

    // Output pins read back their own drive; input pins follow the outside world.
    assign portIn = (portOut & ~portOe_n) | (ext & portOe_n);

    always #2 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wb(input logic [7:0] d, input logic oth, input logic e);
        m.wbyte(d, oth, ack);
        chk("ack", {15'h0, e}, {15'h0, ack});
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d0,
                      input logic [7:0] d1);
        m.start();
        wb({a, 1'b0}, 1'b0, 1'b0);
        wb(c, 1'b0, 1'b0);
        wb(d0, 1'b0, 1'b0);
        wb(d1, 1'b0, 1'b0);
        m.stop();
        tick(4);
    endtask

    task automatic newext();
        rnd = $random(seed);
        ext = (rnd[15:0] & 16'hF00F) | 16'h0001;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(m.rdDone) begin
        if (expQ.size() == 0) begin
            mismatches++;
            $display("CHECK FAILED read expected none seen %h", m.rdByte);
        end else
            chk("read", expQ.pop_front(), {8'h00, m.rdByte});
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        $display("CHECK FAILED run expected end seen timeout");
        give_verdict();
    end

    initial begin
        ref_clk = 1'b0;
        arst_n = 1'b0;
        portSupplyOk = 1'b1;
        addrSel = 1'b0;
        ext = 16'h0000;
        mismatches = 0;
        checked = 0;
        tick(1);
        chk("oe", 16'hFFFF, portOe_n);
        chk("out", 16'hFFFF, portOut);
        chk("idle", 16'h0003, {13'h0, sdaOut, alertOe_n, sdaOe_n});
        tick(1);
        arst_n = 1'b1;
        tick(150);
        wr(7'h20, 8'h02, 8'h5A, 8'hA5);
        wr(7'h20, 8'h06, 8'h0F, 8'hF0);
        chk("out", 16'hA55A, portOut);
        chk("oe", 16'hF00F, portOe_n);
        newext();
        tick(ACYC - 4);
        chk("alert", 16'h0001, {15'h0, alertOe_n});
        tick(14);
        chk("alert", 16'h0000, {14'h0, alertOe_n, alertOut});
        // Nobody answers this address, so the transfer must not touch the alert.
        m.start();
        wb({7'h22, 1'b0}, 1'b0, 1'b1);
        m.stop();
        tick(2);
        chk("alert", 16'h0000, {15'h0, alertOe_n});
        ext = 16'h0000;
        tick(6);
        chk("alert", 16'h0001, {15'h0, alertOe_n});
        m.start();
        wb({7'h20, 1'b0}, 1'b0, 1'b0);
        wb(8'h00, 1'b0, 1'b0);
        m.stop();
        tick(4);
        newext();
        tick(ACYC + 10);
        chk("alert", 16'h0000, {15'h0, alertOe_n});
        pins = (16'hA55A & 16'h0FF0) | (ext & 16'hF00F);
        expQ.push_back({8'h00, pins[7:0]});
        expQ.push_back({8'h00, pins[15:8]});
        m.start();
        wb({7'h20, 1'b1}, 1'b0, 1'b0);
        m.rbyte(1'b0);
        tick(2);
        chk("alert", 16'h0001, {15'h0, alertOe_n});
        m.rbyte(1'b1);
        m.stop();
        chk("sda", 16'h0001, {15'h0, sdaOe_n});
        ext = ext ^ 16'h0001;
        tick(ACYC + 10);
        chk("alert", 16'h0000, {15'h0, alertOe_n});
        // Command is still 00h, so another slave's read acknowledge drops the alert.
        m.start();
        wb({7'h50, 1'b1}, 1'b1, 1'b0);
        m.stop();
        tick(2);
        chk("alert", 16'h0001, {15'h0, alertOe_n});
        // A non-zero pointer keeps the alert through another slave's read.
        m.start();
        wb({7'h20, 1'b0}, 1'b0, 1'b0);
        wb(8'h02, 1'b0, 1'b0);
        m.stop();
        ext = ext ^ 16'h0001;
        tick(ACYC + 10);
        m.start();
        wb({7'h50, 1'b1}, 1'b1, 1'b0);
        m.stop();
        tick(2);
        chk("alert", 16'h0000, {15'h0, alertOe_n});
        arst_n = 1'b0;
        tick(1);
        chk("out", 16'hFFFF, portOut);
        chk("oe", 16'hFFFF, portOe_n);
        arst_n = 1'b1;
        addrSel = 1'b1;
        tick(150);
        wr(7'h21, 8'h06, 8'h00, 8'h00);
        chk("oe", 16'h0000, portOe_n);
        chk("out", 16'hFFFF, portOut);
        portSupplyOk = 1'b0;
        tick(4);
        chk("oe", 16'hFFFF, portOe_n);
        portSupplyOk = 1'b1;
        tick(4);
        chk("queue", 16'h0000, 16'(expQ.size()));
        give_verdict();
    end
endmodule // tb
